// File: pbhp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and an asynchronous active-low reset copy.
`timescale 1ns/10ps
`default_nettype none
module pbhp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;
	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
	// Storage needs no reset; valid guards every read
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
endmodule
`default_nettype wire

// File: pbhp_host.sv
// Host model for the byte port: block writes, download writes, reads.
// Assumes one task call at a time, paced by the device clock.
`timescale 1ns/10ps
`default_nettype none
module pbhp_host (
	// Clock
	input wire logic clk,
	// Device pins
	input wire logic rdy_n,
	input wire logic avl_n,
	input wire logic eob_n,
	input wire logic [7:0] din,
	output logic req,
	output logic stb_n,
	output logic [7:0] dout,
	// Hang flag
	output logic fail
);
	initial
	begin
		req = 1'h0;
		stb_n = 1'h1;
		dout = 8'h00;
		fail = 1'h0;
	end
	// Bounded wait on a pin; a hang shows as fail
	task automatic wt(input int sel, input logic lvl);
		int n;
		n = 0;
		while (((sel == 0) ? rdy_n : (sel == 1) ? avl_n : eob_n) !== lvl && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
			fail = 1'h1;
	endtask
	task automatic hold(input logic r);
		req <= r;
	endtask
	task automatic blk(input logic [7:0] b);
		wt(2, 1'h1);
		@(posedge clk);
		dout <= b;
		req <= 1'h1;
		wt(0, 1'h0);
		wt(0, 1'h1);
		@(posedge clk);
		req <= 1'h0;
		dout <= ~b;
		// Long enough low for the pin synchroniser
		repeat (5) @(posedge clk);
	endtask
	task automatic dl(input logic [7:0] b);
		wt(0, 1'h0);
		@(posedge clk);
		dout <= b;
		repeat (6) @(posedge clk);
		stb_n <= 1'h0;
		repeat (16) @(posedge clk);
		stb_n <= 1'h1;
		repeat (6) @(posedge clk);
		dout <= ~b;
		wt(0, 1'h1);
	endtask
	task automatic rd(output logic [7:0] b);
		req <= 1'h1;
		dout <= ~dout;
		wt(1, 1'h0);
		@(posedge clk);
		stb_n <= 1'h0;
		repeat (33) @(posedge clk);
		b = din;
		stb_n <= 1'h1;
	endtask
endmodule
`default_nettype wire

// File: pbhp_pkg.sv
// Package for the parallel byte handshake port: modes, timing counts, carriers.
// Assumes a 100 MHz core clock; no other file defines these values.
package pbhp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Block sizes in bytes per decoder type
	localparam logic [4:0] BLOCK_BYTES_AUDIO = 5'h1E;
	localparam logic [4:0] BLOCK_BYTES_SPEECH = 5'h0A;
	// Download mode: ready pulled low again no sooner than this after strobe release
	localparam int READY_MIN_NS = 400;
	localparam int READY_MIN_CYC = (READY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Block mode: end-of-block low time before re-arming
	localparam int EOB_HOLD_NS = 1500;
	localparam int EOB_HOLD_CYC = (EOB_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 8;
	localparam int BYTE_W = 8;
	typedef enum logic [1:0] {PBHP_MODE_BLOCK, PBHP_MODE_DOWNLOAD, PBHP_MODE_OUTPUT} pbhp_mode_t;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} pbhp_word_t;
endpackage

// File: pbhp_port.sv
// Parallel byte handshake port, device side: block, download and output modes.
// Assumes pins arrive asynchronous to MCLK; core logic drains RX_* and fills TX_*.
// How it works
// - Request rise: sample data, pull ready low
// - End-of-block low after full block taken
// - Block is 30 audio or 10 speech bytes
// - Download: ready low until byte written
// - Sample on strobe fall, ready high after rise
// - Device alone re-arms ready for next byte
// - Output direction only when software enables
// - Byte-available low while byte held, until read
// - Data driven from strobe fall to rise
`timescale 1ns/10ps
`default_nettype none
module pbhp_port (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Configuration from core
	input wire pbhp_pkg::pbhp_mode_t MODE,
	input wire logic OUTPUT_ENABLE,
	input wire logic SPEECH_MODE,
	// Port pins
	input wire logic TRANSFER_REQUEST,
	input wire logic BYTE_STROBE_N,
	input wire logic [7:0] PARALLEL_DATA_LINES_IN,
	output logic [7:0] PARALLEL_DATA_LINES_OUT,
	output logic PARALLEL_DATA_LINES_OE,
	output logic READY_TO_RECEIVE_N,
	output logic BYTE_AVAILABLE_N,
	output logic END_OF_BLOCK_N,
	// Received bytes to core
	output logic RX_VALID,
	input wire logic RX_READY,
	output logic [7:0] RX_DATA,
	output logic RX_LAST,
	// Bytes from core for output
	input wire logic TX_VALID,
	output logic TX_READY,
	input wire logic [7:0] TX_DATA
);
	logic rst_s1, rst_n;
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Three-stage pin synchronisers; a change counts when stages 2 and 3 agree
	logic [2:0] req_s, stb_s;
	logic req, stb_n, req_prev, stb_prev;
	logic next_req, next_stb_n;
	always_comb
	begin
		next_req = (req_s[1] == req_s[2]) ? req_s[2] : req;
		next_stb_n = (stb_s[1] == stb_s[2]) ? stb_s[2] : stb_n;
	end
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_s <= 3'h0;
			stb_s <= 3'h7;
			req <= 1'b0;
			stb_n <= 1'b1;
			req_prev <= 1'b0;
			stb_prev <= 1'b1;
		end
		else
		begin
			req_s <= {req_s[1:0], TRANSFER_REQUEST};
			stb_s <= {stb_s[1:0], BYTE_STROBE_N};
			req <= next_req;
			stb_n <= next_stb_n;
			req_prev <= req;
			stb_prev <= stb_n;
		end
	end
	logic req_rise, stb_fall, stb_rise;
	assign req_rise = req && !req_prev;
	assign stb_fall = !stb_n && stb_prev;
	assign stb_rise = stb_n && !stb_prev;

	// Data bus sampled through two flops; host holds it well past our latency
	logic [7:0] din_a, din_b;
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			din_a <= 8'h00;
			din_b <= 8'h00;
		end
		else
		begin
			din_a <= PARALLEL_DATA_LINES_IN;
			din_b <= din_a;
		end
	end

	typedef enum logic [2:0] {S_IDLE, S_BLK_WAIT, S_BLK_ACK, S_BLK_END, S_DL_READY,
		S_DL_STROBE, S_DL_GAP, S_OUT} pbhp_state_t;
	pbhp_state_t state, next_state;
	logic [4:0] byte_cnt, next_byte_cnt;
	logic [8:0] timer, next_timer;
	logic rtr_n, next_rtr_n, eob_n, next_eob_n;
	// A rise seen while the FIFO is full must not be lost, so it is held as armed
	logic armed, next_armed;
	logic avail_n, next_avail_n, drive, next_drive;
	logic [7:0] dout, next_dout;
	logic wr_valid, wr_ready, wr_last;
	logic [7:0] wr_data;
	logic [4:0] block_len;
	logic out_on;

	// Speech decoding uses the short block
	assign block_len = SPEECH_MODE ? pbhp_pkg::BLOCK_BYTES_SPEECH : pbhp_pkg::BLOCK_BYTES_AUDIO;
	assign out_on = (MODE == pbhp_pkg::PBHP_MODE_OUTPUT) && OUTPUT_ENABLE;

	always_comb
	begin
		next_state = state;
		next_byte_cnt = byte_cnt;
		next_timer = (timer != 9'h000) ? timer - 9'h001 : timer;
		next_rtr_n = rtr_n;
		next_eob_n = eob_n;
		next_avail_n = avail_n;
		next_drive = drive;
		next_dout = dout;
		next_armed = armed || !req;
		wr_valid = 1'b0;
		wr_last = 1'b0;
		wr_data = din_b;
		TX_READY = 1'b0;
		unique case (state)
			S_IDLE:
			begin
				next_rtr_n = 1'b1;
				next_avail_n = 1'b1;
				next_drive = 1'b0;
				next_eob_n = 1'b1;
				next_byte_cnt = 5'h00;
				if (MODE == pbhp_pkg::PBHP_MODE_BLOCK)
					next_state = S_BLK_WAIT;
				else if (MODE == pbhp_pkg::PBHP_MODE_DOWNLOAD)
					next_state = S_DL_READY;
				else if (out_on)
					next_state = S_OUT;
			end
			S_BLK_WAIT:
			begin
				if (req && armed && wr_ready)
				begin
					next_armed = 1'b0;
					wr_valid = 1'b1;
					wr_last = (byte_cnt == block_len - 5'h01);
					next_rtr_n = 1'b0;
					next_state = S_BLK_ACK;
				end
				else if (MODE != pbhp_pkg::PBHP_MODE_BLOCK)
					next_state = S_IDLE;
			end
			S_BLK_ACK:
			begin
				// Ready released after one cycle low; a full FIFO delays the next byte instead
				next_rtr_n = 1'b1;
				if (byte_cnt == block_len - 5'h01)
				begin
					next_byte_cnt = 5'h00;
					next_eob_n = 1'b0;
					next_timer = 9'(pbhp_pkg::EOB_HOLD_CYC);
					next_state = S_BLK_END;
				end
				else
				begin
					next_byte_cnt = byte_cnt + 5'h01;
					next_state = S_BLK_WAIT;
				end
			end
			S_BLK_END:
			begin
				// Re-arm only after request is low
				if (timer == 9'h000 && !req)
				begin
					next_eob_n = 1'b1;
					next_state = S_BLK_WAIT;
				end
			end
			S_DL_READY:
			begin
				// Device pulls ready low when FIFO has room
				next_rtr_n = !wr_ready;
				if (stb_fall && !rtr_n && wr_ready)
				begin
					wr_valid = 1'b1;
					next_state = S_DL_STROBE;
				end
				else if (MODE != pbhp_pkg::PBHP_MODE_DOWNLOAD)
					next_state = S_IDLE;
			end
			S_DL_STROBE:
			begin
				if (stb_rise)
				begin
					next_rtr_n = 1'b1;
					next_timer = 9'(pbhp_pkg::READY_MIN_CYC);
					next_state = S_DL_GAP;
				end
			end
			S_DL_GAP:
			begin
				if (timer == 9'h000)
					next_state = S_DL_READY;
			end
			S_OUT:
			begin
				// Load a byte and flag it
				if (avail_n && TX_VALID && stb_n)
				begin
					TX_READY = 1'b1;
					next_dout = TX_DATA;
					next_avail_n = 1'b0;
				end
				// Drive only inside a read strobe
				if (stb_fall && !avail_n)
					next_drive = 1'b1;
				if (stb_rise && drive)
				begin
					next_drive = 1'b0;
					next_avail_n = 1'b1;
				end
				if (!out_on && !drive)
					next_state = S_IDLE;
			end
			default:
				next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			byte_cnt <= 5'h00;
			timer <= 9'h000;
			rtr_n <= 1'b1;
			eob_n <= 1'b1;
			avail_n <= 1'b1;
			drive <= 1'b0;
			dout <= 8'h00;
			armed <= 1'b0;
		end
		else
		begin
			armed <= next_armed;
			state <= next_state;
			byte_cnt <= next_byte_cnt;
			timer <= next_timer;
			rtr_n <= next_rtr_n;
			eob_n <= next_eob_n;
			avail_n <= next_avail_n;
			drive <= next_drive;
			dout <= next_dout;
		end
	end

	assign READY_TO_RECEIVE_N = rtr_n;
	assign END_OF_BLOCK_N = eob_n;
	assign BYTE_AVAILABLE_N = avail_n;
	assign PARALLEL_DATA_LINES_OE = drive;
	assign PARALLEL_DATA_LINES_OUT = dout;

	pbhp_pkg::pbhp_word_t fifo_in, fifo_out;
	logic fifo_valid;
	assign fifo_in = '{data: wr_data, last: wr_last};
	pbhp_fifo #(.WIDTH(pbhp_pkg::BYTE_W + 1), .DEPTH(pbhp_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk(MCLK),
		.rst_n(rst_n),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(fifo_in),
		.out_valid(fifo_valid),
		.out_ready(RX_READY),
		.out_data(fifo_out)
	);
	assign RX_VALID = fifo_valid;
	assign RX_DATA = fifo_out.data;
	assign RX_LAST = fifo_out.last;

	// Bus driven only while a read strobe is seen low
	drive_in_strobe_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		$rose(drive) |-> $past(stb_fall)) else $error("data driven without strobe fall");
	input_release_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		(state != S_OUT) |-> !drive) else $error("data driven in input mode");
	ready_after_req_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		(state == S_BLK_WAIT && req && armed && wr_ready) |=> !rtr_n) else $error("ready missing");
	eob_block_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		$fell(eob_n) |-> $past(byte_cnt) == block_len - 5'h01) else $error("early end");
	dl_ready_hold_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		(state == S_DL_STROBE) |-> !rtr_n || stb_rise) else $error("ready rose early");
	avail_hold_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		$rose(avail_n) |-> $past(stb_rise) && $past(drive)) else $error("avail dropped");
	out_gate_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		$fell(avail_n) |-> $past(out_on)) else $error("output not enabled");
	dl_gap_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		$rose(rtr_n) && state == S_DL_GAP |-> ##1 rtr_n [*8]) else $error("gap short");
endmodule
`default_nettype wire

// File: pbhp_port_tb.sv
// Bench for the byte port: host model, reference queue, all three modes.
// Assumes the package, FIFO, port and host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module pbhp_port_tb;
	logic mclk = 1'h0;
	logic resetn = 1'h0;
	pbhp_pkg::pbhp_mode_t mode = pbhp_pkg::PBHP_MODE_BLOCK;
	logic out_en = 1'h0;
	logic speech = 1'h1;
	logic rx_ready = 1'h0;
	logic rx_hold = 1'h0;
	logic tx_valid = 1'h0;
	logic [7:0] tx_data = 8'h00;
	wire logic req, stb_n, oe, rdy_n, avl_n, eob_n, rx_valid, rx_last, tx_ready, fail;
	wire logic [7:0] hdout, pout, rx_data;
	wire logic [7:0] bus = oe ? pout : hdout;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	logic [7:0] b;
	always #5 mclk = ~mclk;
	pbhp_port i_dut (.MCLK(mclk), .RESETN(resetn), .MODE(mode), .OUTPUT_ENABLE(out_en),
		.SPEECH_MODE(speech), .TRANSFER_REQUEST(req), .BYTE_STROBE_N(stb_n),
		.PARALLEL_DATA_LINES_IN(bus), .PARALLEL_DATA_LINES_OUT(pout),
		.PARALLEL_DATA_LINES_OE(oe), .READY_TO_RECEIVE_N(rdy_n), .BYTE_AVAILABLE_N(avl_n),
		.END_OF_BLOCK_N(eob_n), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data),
		.RX_LAST(rx_last), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data));
	pbhp_host i_host (.clk(mclk), .rdy_n(rdy_n), .avl_n(avl_n), .eob_n(eob_n), .din(bus),
		.req(req), .stb_n(stb_n), .dout(hdout), .fail(fail));
	task automatic print_verdict();
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Reference model: every byte taken by the core is popped and compared
	always @(posedge mclk)
	begin
		rx_ready <= !rx_hold && $urandom_range(1, 0) == 1;
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			print_verdict();
		end
		if (rx_valid === 1'h1 && rx_ready === 1'h1)
		begin
			`CHK(exp_q.size() != 0, 1'h1)
			e = exp_q.pop_front();
			`CHK(rx_data, e[7:0])
			`CHK(rx_last, e[8])
		end
	end
	task automatic send_blk(input int n);
		for (int i = 0; i < n; i++)
		begin
			b = 8'($urandom);
			exp_q.push_back({i == n - 1, b});
			if (i == n - 1)
				`CHK(eob_n, 1'h1)
			i_host.blk(b);
			`CHK(oe, 1'h0)
		end
		repeat (12) @(posedge mclk);
		`CHK(eob_n, 1'h0)
	endtask
	task automatic out_byte();
		tx_data <= 8'($urandom);
		tx_valid <= 1'h1;
		do @(posedge mclk); while (tx_ready !== 1'h1);
		tx_valid <= 1'h0;
		i_host.rd(b);
		`CHK(b, tx_data)
		`CHK(oe, 1'h1)
		repeat (10) @(posedge mclk);
		`CHK(oe, 1'h0)
		`CHK(avl_n, 1'h1)
	endtask
	initial
	begin
		void'($urandom(32'h32FB));
		repeat (3) @(posedge mclk);
		resetn <= 1'h1;
		repeat (6) @(posedge mclk);
		// Core stalls so the FIFO fills and ready is held off
		rx_hold <= 1'h1;
		fork
		begin
			repeat (300) @(posedge mclk);
			rx_hold <= 1'h0;
		end
		join_none
		send_blk(10);
		speech <= 1'h0;
		send_blk(30);
		repeat (200) @(posedge mclk);
		mode <= pbhp_pkg::PBHP_MODE_DOWNLOAD;
		repeat (5) @(posedge mclk);
		for (int i = 0; i < 4; i++)
		begin
			b = 8'($urandom);
			exp_q.push_back({1'h0, b});
			i_host.dl(b);
			repeat (20) @(posedge mclk);
			`CHK(rdy_n, 1'h1)
			`CHK(oe, 1'h0)
		end
		repeat (60) @(posedge mclk);
		`CHK(exp_q.size(), 0)
		i_host.hold(1'h1);
		mode <= pbhp_pkg::PBHP_MODE_OUTPUT;
		tx_valid <= 1'h1;
		repeat (30) @(posedge mclk);
		`CHK(avl_n, 1'h1)
		tx_valid <= 1'h0;
		out_en <= 1'h1;
		repeat (5) @(posedge mclk);
		repeat (4) out_byte();
		`CHK(fail, 1'h0)
		print_verdict();
	end
endmodule
`default_nettype wire
